// ===== design/dpd_pkg.sv
/*
 * Constants and carrier types for the probe detect and chip erase unit.
 * Assumes the memory and flash wipers answer with one-cycle done pulses.
 */
// Summary of operation
// R1 - Hot or cold plugging detected sets the probe present flag.
// R2 - While the security lock is active, hot plugging is not accepted.
// R3 - No detection before power-on reset has been released.
// R4 - Probe holds external reset longer than power-on reset on a locked part.
// R5 - Probe retries connection if reset released before power-on reset ends.
// R6 - On a locked part the probe resets the device to be recognised.
// R7 - After lock removal internal registers are returned to reset state.
// R8 - Chip erase clears the lock, volatile memories and whole main flash.
// R9 - Chip erase leaves auxiliary flash rows and user row untouched.
// R10 - Writing one to the erase trigger starts erase; zero does nothing.
// R11 - Erase request ignored while the access guard write-protects the unit.
// R12 - Volatile memory clearing completes before flash array erase begins.
// R13 - Erase completion reported by a done flag in the primary status.
// R14 - Probe should issue erase only after cold-plug detection.
// R15 - On cold-plug detection the CPU is held in reset.
// R16 - Done reads low from accepted erase start until both phases end; the code also keeps it low through the register reset phase.
// R17 - CPU stays held in reset for a whole erase after cold plug.
package dpd_pkg;
    // ------------------------------------------------------------
    // erase sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DPD_IDLE = 2'b00,
        DPD_VOL = 2'b01,
        DPD_FLASH = 2'b10,
        DPD_RESET = 2'b11
    } dpd_state_t;

    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic DPD_DONE_RST = 1'b0;
    localparam logic DPD_PRESENT_RST = 1'b0;
    localparam int DPD_REG_RST_NS = 80;
    localparam int DPD_CLK_NS = 40;
    localparam int DPD_REG_RST_CYC = (DPD_REG_RST_NS + DPD_CLK_NS - 1) / DPD_CLK_NS;

    // erase targets driven to the memory side
    typedef struct packed {
        logic vol_clear;   // volatile memory wipe request
        logic flash_erase; // main array plus emulated eeprom, aux rows excluded
        logic lock_clear;  // clear security lock
        logic regs_reset;  // internal register reset after lock removal
    } dpd_erase_t;
endpackage : dpd_pkg

// ===== design/dpd_unit.sv
/*
 * Probe detection and chip erase sequencer of the service unit.
 * Assumes the debug link clock runs only while the probe is attached and that
 * the memory side wipers return one-cycle done pulses on sys_clk.
 */
`timescale 1ns/1ns
module dpd_unit (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic link_clk,
    input wire logic ext_reset_b,
    input wire logic por_done,
    input wire logic lock_active,
    input wire logic guard_protect,
    input wire logic erase_wr,
    input wire logic erase_wdata,
    input wire logic vol_done,
    input wire logic flash_done,
    output logic probe_present_flag,
    output logic cold_plug_flag,
    output logic status_done,
    output logic cpu_hold_reset,
    output dpd_pkg::dpd_erase_t erase_req
);
    // ------------------------------------------------------------
    // link side: toggle on every rising link edge marks link activity
    // ------------------------------------------------------------
    logic link_tog_q;
    logic [2:0] tog_sync_q;
    logic [1:0] rst_sync_q;
    logic [1:0] por_sync_q;

    // link clock lives only in the link domain; only the toggle crosses
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            link_tog_q <= 1'b0;
        end else begin
            link_tog_q <= ~link_tog_q;
        end
    end

    // synchronisers for the toggle and asynchronous pins
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tog_sync_q <= 3'h0;
            // idle level of the pin is high; a zero here would fake a held reset
            rst_sync_q <= 2'h3;
            por_sync_q <= 2'h0;
        end else begin
            tog_sync_q <= {tog_sync_q[1:0], link_tog_q};
            rst_sync_q <= {rst_sync_q[0], ext_reset_b};
            por_sync_q <= {por_sync_q[0], por_done};
        end
    end

    logic link_edge;
    logic ext_rst_low;
    logic por_ok;
    assign link_edge = tog_sync_q[2] ^ tog_sync_q[1];
    assign ext_rst_low = ~rst_sync_q[1];
    assign por_ok = por_sync_q[1];

    // ------------------------------------------------------------
    // detection
    // ------------------------------------------------------------
    logic cold_det;
    logic hot_det;
    // cold: link activity while external reset held after por release
    assign cold_det = por_ok & ext_rst_low & link_edge; // [R3] [R15]
    // hot: link activity with reset released, refused on a locked part
    assign hot_det = por_ok & ~ext_rst_low & link_edge & ~lock_active; // [R2] [R3]

    logic present_q;
    logic cold_q;
    // flags are sticky until reset; nothing clears them here
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            present_q <= dpd_pkg::DPD_PRESENT_RST;
            cold_q <= 1'b0;
        end else begin
            if (cold_det || hot_det) begin
                present_q <= 1'b1; // [R1]
            end
            if (cold_det) begin
                cold_q <= 1'b1; // [R15]
            end
        end
    end
    assign probe_present_flag = present_q;
    assign cold_plug_flag = cold_q;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // the register reset counter is four bits wide; a longer hold would wrap
    // and a zero count would wrap to a sixteen-cycle reset phase
    if (dpd_pkg::DPD_REG_RST_CYC < 1 || dpd_pkg::DPD_REG_RST_CYC > 15) begin : g_bad_rst_cyc
        $error("register reset cycle count out of range");
    end

    // ------------------------------------------------------------
    // erase sequencer
    // ------------------------------------------------------------
    dpd_pkg::dpd_state_t state_q;
    logic done_q;
    logic [3:0] rst_cnt_q;
    logic start;
    // a write of one starts erase unless guarded or busy
    assign start = erase_wr & erase_wdata & ~guard_protect
                   & (state_q == dpd_pkg::DPD_IDLE); // [R10] [R11]

    // state walk: volatile wipe, flash erase, then register reset
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= dpd_pkg::DPD_IDLE;
            rst_cnt_q <= 4'h0;
        end else begin
            unique case (state_q)
                dpd_pkg::DPD_IDLE: begin
                    if (start) begin
                        state_q <= dpd_pkg::DPD_VOL;
                    end
                end
                dpd_pkg::DPD_VOL: begin
                    if (vol_done) begin
                        state_q <= dpd_pkg::DPD_FLASH; // [R12]
                    end
                end
                dpd_pkg::DPD_FLASH: begin
                    if (flash_done) begin
                        state_q <= dpd_pkg::DPD_RESET;
                        rst_cnt_q <= 4'(dpd_pkg::DPD_REG_RST_CYC);
                    end
                end
                dpd_pkg::DPD_RESET: begin
                    // registers held in reset a few cycles after lock removal
                    if (rst_cnt_q == 4'h1) begin
                        state_q <= dpd_pkg::DPD_IDLE; // [R7]
                    end
                    rst_cnt_q <= rst_cnt_q - 4'h1;
                end
            endcase
        end
    end

    // done low from accepted start until every phase has ended
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            done_q <= dpd_pkg::DPD_DONE_RST;
        end else if (start) begin
            done_q <= 1'b0; // [R16]
        end else if (state_q == dpd_pkg::DPD_RESET && rst_cnt_q == 4'h1) begin
            done_q <= 1'b1; // [R13]
        end
    end
    assign status_done = done_q;

    // outputs to the memory side; aux rows have no request line at all
    always_comb begin
        erase_req.vol_clear = (state_q == dpd_pkg::DPD_VOL); // [R8] [R12]
        erase_req.flash_erase = (state_q == dpd_pkg::DPD_FLASH); // [R8] [R9]
        erase_req.lock_clear = (state_q == dpd_pkg::DPD_FLASH) & flash_done; // [R8]
        erase_req.regs_reset = (state_q == dpd_pkg::DPD_RESET); // [R7]
    end

    // cpu held after cold plug, and through any erase
    assign cpu_hold_reset = cold_q | (state_q != dpd_pkg::DPD_IDLE); // [R15] [R17]

    // ------------------------------------------------------------
    // check helpers
    // ------------------------------------------------------------
    // length of the current register reset phase, for the checks only;
    // saturates so a stuck phase cannot wrap back to a legal length
    logic [3:0] rst_len_q;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_len_q <= 4'h0;
        end else if (!erase_req.regs_reset) begin
            rst_len_q <= 4'h0;
        end else if (rst_len_q != 4'hf) begin
            rst_len_q <= rst_len_q + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_hot_locked: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!present_q && lock_active && !ext_rst_low) |=> !present_q) // [R2]
        else $error("hot plug accepted while locked");
    chk_no_por_det: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!present_q && !por_ok) |=> !present_q) // [R3]
        else $error("detection before por release");
    chk_present_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (cold_det || hot_det) |=> present_q) // [R1]
        else $error("present flag not set on detection");
    chk_guard_drop: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (state_q == dpd_pkg::DPD_IDLE && guard_protect) |=> state_q == dpd_pkg::DPD_IDLE) // [R11]
        else $error("erase accepted while guarded");
    chk_start_one: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (state_q == dpd_pkg::DPD_IDLE && erase_wr && erase_wdata && !guard_protect)
        |=> erase_req.vol_clear && !done_q) // [R10]
        else $error("erase not started on write of one");
    chk_vol_first: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(erase_req.flash_erase) |-> $past(erase_req.vol_clear) && $past(vol_done)) // [R12]
        else $error("flash erase before volatile wipe");
    chk_done_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (state_q != dpd_pkg::DPD_IDLE) |-> !done_q) // [R16]
        else $error("done high during erase");
    chk_done_end: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (erase_req.flash_erase && flash_done) |-> ##3 done_q) // [R13]
        else $error("done not raised after erase");
    chk_cpu_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cold_det |=> cpu_hold_reset [*3]) // [R15] [R17]
        else $error("cpu released after cold plug");
    chk_lock_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
        erase_req.lock_clear |=> erase_req.regs_reset) // [R7] [R8]
        else $error("registers not reset after lock removal");

    // presence is sticky: only rst_b may take it away
    chk_present_keep: assert property (@(posedge sys_clk) disable iff (!rst_b)
        present_q |=> present_q) // [R1]
        else $error("probe present flag dropped");
    // the cold plug mark is sticky too, so the cpu stays held
    chk_cold_keep: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cold_q |=> cold_q) // [R15]
        else $error("cold plug flag dropped");
    // a cold plug is a detection as well
    chk_cold_present: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cold_q |-> present_q) // [R1]
        else $error("cold plug without present flag");
    // a hot plug must never be taken for a cold one
    chk_hot_not_cold: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (hot_det && !cold_q) |=> !cold_q) // [R1]
        else $error("hot plug marked as cold");
    // cold plug holds the cpu at once
    chk_cold_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cold_q |-> cpu_hold_reset) // [R15]
        else $error("cpu running after cold plug");
    // any erase phase keeps the cpu held, cold plug or not
    chk_busy_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (state_q != dpd_pkg::DPD_IDLE) |-> cpu_hold_reset) // [R17]
        else $error("cpu released during erase");
    // a write of zero leaves the sequencer idle
    chk_zero_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (state_q == dpd_pkg::DPD_IDLE && erase_wr && !erase_wdata)
        |=> state_q == dpd_pkg::DPD_IDLE) // [R10]
        else $error("zero write started erase");
    // no request line moves while idle; aux rows never see one at all
    chk_idle_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (state_q == dpd_pkg::DPD_IDLE) |-> (erase_req == 4'h0)) // [R8] [R9]
        else $error("erase request while idle");
    // volatile wipe stays requested until its done pulse
    chk_vol_stay: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (erase_req.vol_clear && !vol_done) |=> erase_req.vol_clear) // [R12]
        else $error("volatile wipe dropped early");
    // flash erase stays requested until its done pulse
    chk_flash_stay: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (erase_req.flash_erase && !flash_done) |=> erase_req.flash_erase) // [R12]
        else $error("flash erase dropped early");
    // volatile wipe and flash erase never overlap
    chk_phase_excl: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !(erase_req.vol_clear && erase_req.flash_erase)) // [R12]
        else $error("volatile and flash phases overlap");
    // the lock is only cleared as the flash erase ends
    chk_lock_late: assert property (@(posedge sys_clk) disable iff (!rst_b)
        erase_req.lock_clear |-> erase_req.flash_erase) // [R8]
        else $error("lock cleared outside flash phase");
    // register reset lasts exactly the configured number of cycles
    chk_rst_len: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $fell(erase_req.regs_reset) |-> rst_len_q == 4'(dpd_pkg::DPD_REG_RST_CYC)) // [R7]
        else $error("register reset phase has wrong length");
    // done only rises as the sequencer returns to idle
    chk_done_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(done_q) |-> state_q == dpd_pkg::DPD_IDLE) // [R13] [R16]
        else $error("done raised outside idle");

    cov_cold: cover property (@(posedge sys_clk) disable iff (!rst_b) cold_det);
    cov_hot: cover property (@(posedge sys_clk) disable iff (!rst_b) hot_det);
    cov_erase: cover property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(done_q));
    // the recommended order: erase started after a cold plug
    cov_cold_erase: cover property (@(posedge sys_clk) disable iff (!rst_b)
        cold_q && start);
    // a guarded write of one turned away
    cov_guard_refuse: cover property (@(posedge sys_clk) disable iff (!rst_b)
        state_q == dpd_pkg::DPD_IDLE && erase_wr && erase_wdata && guard_protect);
endmodule : dpd_unit

// ===== verification/dpd_probe_model.sv
/* probe model: drives the debug link clock and the external reset pin.
   assumes the bench opens a frame with run and holds reset with hold_rst. */
`timescale 1ns/1ns
module dpd_probe_model (
    input wire logic run,
    input wire logic hold_rst,
    output logic link_clk,
    output logic ext_reset_b
);
    // link clock runs only inside a frame, parked low between frames
    initial begin
        link_clk = 1'b0;
        #17;
        forever begin
            if (run) begin
                #62 link_clk = 1'b1;
                #63 link_clk = 1'b0;
            end else begin
                #5;
            end
        end
    end
    // reset held past power-on release so cold plug works
    assign ext_reset_b = !hold_rst;
endmodule : dpd_probe_model

// ===== verification/dpd_unit_tb.sv
/* bench for dpd_unit: probe detection and chip erase sequencing.
   assumes dpd_probe_model plays the probe; the memory side is played here. */
`timescale 1ns/1ns
module dpd_unit_tb;
    logic sys_clk, rst_b, por_done, lock_active, guard_protect, erase_wr;
    logic erase_wdata, vol_done, flash_done, run, hold_rst, link_clk, ext_reset_b;
    logic probe_present_flag, cold_plug_flag, status_done, cpu_hold_reset;
    dpd_pkg::dpd_erase_t erase_req;
    int n_errors = 0;
    int check_count = 0;
    dpd_unit DUT (.sys_clk(sys_clk), .rst_b(rst_b), .link_clk(link_clk),
        .ext_reset_b(ext_reset_b), .por_done(por_done), .lock_active(lock_active),
        .guard_protect(guard_protect), .erase_wr(erase_wr), .erase_wdata(erase_wdata),
        .vol_done(vol_done), .flash_done(flash_done), .probe_present_flag(probe_present_flag),
        .cold_plug_flag(cold_plug_flag), .status_done(status_done),
        .cpu_hold_reset(cpu_hold_reset), .erase_req(erase_req));
    dpd_probe_model probe (.run(run), .hold_rst(hold_rst), .link_clk(link_clk),
        .ext_reset_b(ext_reset_b));
    // ------------------------------------------------------------
    // clock and helpers
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_sim
    task automatic chk(logic got, logic exp, string msg);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask : chk
    // n rising edges, then look on the falling edge where outputs are settled
    task automatic cyc(int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : cyc
    task automatic restart(logic por);
        @(posedge sys_clk);
        rst_b <= 1'b0;
        por_done <= por;
        lock_active <= 1'b0;
        hold_rst <= 1'b0;
        run <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
    endtask : restart
    // bounded wait; the link needs one of its slow cycles to be seen
    task automatic wait_present();
        int i;
        for (i = 0; i < 60 && probe_present_flag !== 1'b1; i++) @(negedge sys_clk);
        run <= 1'b0;
        if (i == 60) begin
            n_errors++;
            $display("Error at %0t: no probe detected", $time);
            end_sim();
        end
    endtask : wait_present
    task automatic wr(logic d, logic g);
        @(posedge sys_clk);
        erase_wr <= 1'b1;
        erase_wdata <= d;
        guard_protect <= g;
        @(posedge sys_clk);
        erase_wr <= 1'b0;
        guard_protect <= 1'b0;
    endtask : wr
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_hot();
        restart(1'b1);
        lock_active <= 1'b1;
        run <= 1'b1;
        cyc(40);
        chk(probe_present_flag, 1'b0, "hot plug taken while locked");
        @(posedge sys_clk);
        lock_active <= 1'b0;
        wait_present();
        chk(cold_plug_flag, 1'b0, "hot plug seen as cold");
        chk(cpu_hold_reset, 1'b0, "cpu held after hot plug");
        $display("test hot plug finished");
    endtask : t_hot
    task automatic t_cold();
        restart(1'b0);
        hold_rst <= 1'b1;
        run <= 1'b1;
        cyc(40);
        chk(probe_present_flag, 1'b0, "detected before power-on release");
        @(posedge sys_clk);
        por_done <= 1'b1;
        wait_present();
        chk(cold_plug_flag, 1'b1, "cold plug not flagged");
        chk(cpu_hold_reset, 1'b1, "cpu not held");
        $display("test cold plug finished");
    endtask : t_cold
    // refused writes first, then a full erase walked phase by phase
    task automatic t_erase();
        wr(1'b1, 1'b1);
        cyc(2);
        chk(erase_req.vol_clear, 1'b0, "guarded write started erase");
        wr(1'b0, 1'b0);
        cyc(2);
        chk(erase_req.vol_clear, 1'b0, "zero write started erase");
        wr(1'b1, 1'b0);
        cyc(1);
        chk(erase_req.vol_clear, 1'b1, "erase not started");
        chk(status_done, 1'b0, "done high during erase");
        cyc(5);
        chk(erase_req.flash_erase, 1'b0, "flash before volatile end");
        @(posedge sys_clk);
        vol_done <= 1'b1;
        @(posedge sys_clk);
        vol_done <= 1'b0;
        cyc(1);
        chk(erase_req.flash_erase, 1'b1, "flash phase missing");
        chk(cpu_hold_reset, 1'b1, "cpu released during erase");
        @(posedge sys_clk);
        flash_done <= 1'b1;
        @(negedge sys_clk);
        chk(erase_req.lock_clear, 1'b1, "lock not cleared");
        @(posedge sys_clk);
        flash_done <= 1'b0;
        @(negedge sys_clk);
        chk(erase_req.regs_reset, 1'b1, "register reset missing");
        chk(status_done, 1'b0, "done before erase end");
        cyc(1);
        chk(erase_req.regs_reset, 1'b1, "register reset too short");
        cyc(1);
        chk(erase_req.regs_reset, 1'b0, "register reset too long");
        chk(status_done, 1'b1, "done not set");
        $display("test chip erase finished");
    endtask : t_erase
    // second erase straight after the first: done must drop and rise again
    task automatic t_erase2();
        wr(1'b1, 1'b0);
        cyc(1);
        chk(status_done, 1'b0, "done not cleared by new erase");
        chk(cpu_hold_reset, 1'b1, "cpu released in second erase");
        @(posedge sys_clk);
        vol_done <= 1'b1;
        @(posedge sys_clk);
        vol_done <= 1'b0;
        flash_done <= 1'b1;
        @(posedge sys_clk);
        flash_done <= 1'b0;
        cyc(2);
        chk(status_done, 1'b1, "second erase never done");
        $display("test second erase finished");
    endtask : t_erase2
    initial begin
        rst_b = 1'b0;
        {por_done, lock_active, guard_protect, erase_wr, erase_wdata} = 5'h00;
        {vol_done, flash_done, run, hold_rst} = 4'h0;
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_hot();
        t_cold();
        t_erase();
        t_erase2();
        end_sim();
    end
endmodule : dpd_unit_tb
